/* File: verilog/iers_pkg.sv */
// Package with widths, vector layout and state encodings of the entry/return sequencer
package iers_pkg;
  // ==========================================================================
  // Widths and address layout
  // ==========================================================================
  localparam int unsigned         WORD_W      = 16;
  localparam int unsigned         VEC_W       = 8;
  localparam logic [WORD_W-1:0]   WORD_STEP   = 16'h0002;
  localparam logic [WORD_W-1:0]   VEC_PS_OFS  = 16'h0002;
  localparam logic [WORD_W-1:0]   SP_RESET    = 16'h0000;
  localparam logic [WORD_W-1:0]   IP_RESET    = 16'h0000;
  localparam logic [WORD_W-1:0]   PSW_RESET   = 16'h0000;

  // ==========================================================================
  // Command codes from the instruction decoder
  // ==========================================================================
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_RFI  = 2'h1;
  localparam logic [1:0] CMD_XCHG = 2'h2;
  localparam logic [1:0] CMD_SRET = 2'h3;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_PUSH_PSW  = 4'b0001,
    ST_PUSH_IP   = 4'b0010,
    ST_VEC_IP    = 4'b0011,
    ST_VEC_PSW   = 4'b0100,
    ST_POP_IP    = 4'b0101,
    ST_POP_PSW   = 4'b0110,
    ST_XPOP      = 4'b0111,
    ST_XPUSH     = 4'b1000,
    ST_SRPOP     = 4'b1001
  } iers_state_e;
endpackage : iers_pkg

/* File: verilog/iers_sequencer.sv */
// Interrupt entry, interrupt return, co-routine exchange and subroutine return sequencer
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// [RL1] Entry pushes status then pointer, predecrementing
// [RL2] Then fetch two consecutive vector words
// [RL3] First word pointer, second word status
// [RL4] Loaded status sets mode and register set
// [RL5] Device supplies low kernel vector location
// [RL6] Return pops pointer then status, postincrementing
// [RL7] Stack only; no nesting limit
// [RL8] Exchange jump pops target, pushes old pointer
// [RL9] Subroutine return: link to pointer, pop link
// [RL10] Entry accepted only at instruction boundary
module iers_sequencer
  import iers_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_N,
  input  wire logic              IRQ_REQ,
  input  wire logic [VEC_W-1:0]  IRQ_VECTOR,
  input  wire logic              INSN_BOUNDARY,
  input  wire logic [1:0]        CMD,
  input  wire logic [WORD_W-1:0] LINK_IN,
  input  wire logic [WORD_W-1:0] IP_IN,
  input  wire logic [WORD_W-1:0] SP_IN,
  input  wire logic [WORD_W-1:0] PSW_IN,
  input  wire logic [WORD_W-1:0] MEM_RDATA,
  input  wire logic              MEM_ACK,
  output logic                   MEM_REQ,
  output logic                   MEM_WE,
  output logic [WORD_W-1:0]      MEM_ADDR,
  output logic [WORD_W-1:0]      MEM_WDATA,
  output logic [WORD_W-1:0]      INSTRUCTION_POINTER,
  output logic [WORD_W-1:0]      STACK_POINTER,
  output logic [WORD_W-1:0]      PROCESSOR_STATUS_WORD,
  output logic [WORD_W-1:0]      LINK_OUT,
  output logic                   LINK_WE,
  output logic                   IRQ_TAKEN,
  output logic                   BUSY,
  output logic                   DONE
);
  // ==========================================================================
  // Registers
  // ==========================================================================
  iers_state_e       state_q, state_d;
  logic [WORD_W-1:0] ip_q, sp_q, psw_q, vec_q, tmp_q, link_q;
  logic              req_q, we_q, taken_q, done_q, lwe_q, busy_q;
  logic [WORD_W-1:0] addr_q, wdata_q;

  // ==========================================================================
  // Decoding
  // ==========================================================================
  wire logic              idle      = (state_q == ST_IDLE);
  wire logic              busy_d    = (state_d != ST_IDLE);
  wire logic              take_irq  = idle && IRQ_REQ && INSN_BOUNDARY; // [RL10]
  wire logic              start_cmd = idle && !take_irq && (CMD != CMD_NONE);
  wire logic              step      = !idle && MEM_ACK;
  wire logic [WORD_W-1:0] sp_dec    = sp_q - WORD_STEP; // [RL1]
  wire logic [WORD_W-1:0] sp_inc    = sp_q + WORD_STEP; // [RL6]
  // Live stack pointer, the tracked copy lags one cycle behind it
  wire logic [WORD_W-1:0] sp_in_dec = SP_IN - WORD_STEP; // [RL1]
  // Vector sits in low kernel space, location chosen by the device
  wire logic [WORD_W-1:0] vec_addr  = {{(WORD_W-VEC_W){1'b0}}, IRQ_VECTOR}; // [RL5]

  // Next state
  always_comb begin
    state_d = state_q;
    if (take_irq) begin
      state_d = ST_PUSH_PSW;
    end else if (start_cmd) begin
      case (CMD)
        CMD_RFI:  state_d = ST_POP_IP;
        CMD_XCHG: state_d = ST_XPOP;
        CMD_SRET: state_d = ST_SRPOP;
        default:  state_d = ST_IDLE;
      endcase
    end else if (step) begin
      case (state_q)
        ST_PUSH_PSW: state_d = ST_PUSH_IP;  // [RL1]
        ST_PUSH_IP:  state_d = ST_VEC_IP;   // [RL2]
        ST_VEC_IP:   state_d = ST_VEC_PSW;  // [RL2]
        ST_POP_IP:   state_d = ST_POP_PSW;  // [RL6]
        ST_XPOP:     state_d = ST_XPUSH;    // [RL8]
        default:     state_d = ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= busy_d;
    end
  end

  // ==========================================================================
  // Datapath: architectural copies and memory cycle
  // ==========================================================================
  // All state lives on the stack in memory, so nesting depth is unbounded [RL7]
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ip_q    <= IP_RESET;
      sp_q    <= SP_RESET;
      psw_q   <= PSW_RESET;
      vec_q   <= '0;
      tmp_q   <= '0;
      link_q  <= '0;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
      taken_q <= 1'b0;
      done_q  <= 1'b0;
      lwe_q   <= 1'b0;
    end else begin
      taken_q <= take_irq;
      done_q  <= 1'b0;
      lwe_q   <= 1'b0;
      if (idle) begin
        ip_q  <= IP_IN;
        psw_q <= PSW_IN;
        if (take_irq) begin
          // Push status first at SP-2 [RL1]
          sp_q    <= sp_in_dec;
          vec_q   <= vec_addr;
          req_q   <= 1'b1;
          we_q    <= 1'b1;
          addr_q  <= sp_in_dec;
          wdata_q <= PSW_IN;
        end else if (start_cmd) begin
          sp_q    <= SP_IN;
          link_q  <= LINK_IN;
          req_q   <= 1'b1;
          we_q    <= 1'b0;
          addr_q  <= SP_IN;
        end else begin
          sp_q    <= SP_IN;
        end
      end else if (step) begin
        case (state_q)
          ST_PUSH_PSW: begin
            sp_q    <= sp_dec;  // [RL1]
            addr_q  <= sp_dec;
            wdata_q <= ip_q;
          end
          ST_PUSH_IP: begin
            we_q   <= 1'b0;
            addr_q <= vec_q;   // [RL2]
          end
          ST_VEC_IP: begin
            ip_q   <= MEM_RDATA;  // [RL3]
            addr_q <= vec_q + VEC_PS_OFS;
          end
          ST_VEC_PSW: begin
            psw_q  <= MEM_RDATA;  // New mode and register set [RL4] [RL3]
            req_q  <= 1'b0;
            done_q <= 1'b1;
          end
          ST_POP_IP: begin
            ip_q   <= MEM_RDATA;  // [RL6]
            sp_q   <= sp_inc;
            addr_q <= sp_inc;
          end
          ST_POP_PSW: begin
            psw_q  <= MEM_RDATA;  // [RL6]
            sp_q   <= sp_inc;
            req_q  <= 1'b0;
            done_q <= 1'b1;
          end
          ST_XPOP: begin
            // Pop target, SP+2 then SP-2 nets out unchanged [RL8]
            tmp_q   <= MEM_RDATA;
            we_q    <= 1'b1;
            wdata_q <= ip_q;
          end
          ST_XPUSH: begin
            ip_q   <= tmp_q;  // [RL8]
            we_q   <= 1'b0;
            req_q  <= 1'b0;
            done_q <= 1'b1;
          end
          ST_SRPOP: begin
            ip_q   <= link_q;  // [RL9]
            link_q <= MEM_RDATA;
            lwe_q  <= 1'b1;
            sp_q   <= sp_inc;
            req_q  <= 1'b0;
            done_q <= 1'b1;
          end
          default: begin
            req_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign MEM_REQ               = req_q;
  assign MEM_WE                = we_q;
  assign MEM_ADDR              = addr_q;
  assign MEM_WDATA             = wdata_q;
  assign INSTRUCTION_POINTER   = ip_q;
  assign STACK_POINTER         = sp_q;
  assign PROCESSOR_STATUS_WORD = psw_q;
  assign LINK_OUT              = link_q;
  assign LINK_WE               = lwe_q;
  assign IRQ_TAKEN             = taken_q;
  assign BUSY                  = busy_q;
  assign DONE                  = done_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_boundary;
    @(posedge REF_CLK) disable iff (!RST_N)
      IRQ_TAKEN |-> $past(INSN_BOUNDARY);
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry off boundary"); // [RL10]

  property p_push_psw;
    @(posedge REF_CLK) disable iff (!RST_N)
      IRQ_TAKEN |-> MEM_WE && MEM_WDATA == $past(PSW_IN) && MEM_ADDR == $past(SP_IN) - WORD_STEP;
  endproperty
  a_push_psw: assert property (p_push_psw) else $error("status push wrong"); // [RL1]

  property p_push_ip;
    @(posedge REF_CLK) disable iff (!RST_N)
      (state_q == ST_PUSH_PSW && MEM_ACK) |=> MEM_WE && MEM_WDATA == ip_q
        && MEM_ADDR == $past(MEM_ADDR) - WORD_STEP && STACK_POINTER == MEM_ADDR;
  endproperty
  a_push_ip: assert property (p_push_ip) else $error("pointer push wrong"); // [RL1]

  property p_vec_addr;
    @(posedge REF_CLK) disable iff (!RST_N)
      (state_q == ST_PUSH_IP && MEM_ACK) |=> !MEM_WE && MEM_ADDR == vec_q;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong"); // [RL2]

  property p_vec_load;
    @(posedge REF_CLK) disable iff (!RST_N)
      (state_q == ST_VEC_IP && MEM_ACK) |=> INSTRUCTION_POINTER == $past(MEM_RDATA);
  endproperty
  a_vec_load: assert property (p_vec_load) else $error("vector pointer not loaded"); // [RL3]

  property p_vec_psw;
    @(posedge REF_CLK) disable iff (!RST_N)
      (state_q == ST_VEC_PSW && MEM_ACK) |=> PROCESSOR_STATUS_WORD == $past(MEM_RDATA) && DONE;
  endproperty
  a_vec_psw: assert property (p_vec_psw) else $error("vector status not loaded"); // [RL4]

  property p_rfi_sp;
    @(posedge REF_CLK) disable iff (!RST_N)
      (state_q == ST_POP_PSW && MEM_ACK) |=> STACK_POINTER == $past(MEM_ADDR) + WORD_STEP;
  endproperty
  a_rfi_sp: assert property (p_rfi_sp) else $error("return pop pointer wrong"); // [RL6]

  property p_xchg;
    @(posedge REF_CLK) disable iff (!RST_N)
      (state_q == ST_XPOP && MEM_ACK) |=> MEM_WE && MEM_ADDR == $past(MEM_ADDR);
  endproperty
  a_xchg: assert property (p_xchg) else $error("exchange push slot wrong"); // [RL8]

  property p_sret;
    @(posedge REF_CLK) disable iff (!RST_N)
      (state_q == ST_SRPOP && MEM_ACK) |=> INSTRUCTION_POINTER == $past(link_q) && LINK_WE;
  endproperty
  a_sret: assert property (p_sret) else $error("subroutine return wrong"); // [RL9]
endmodule : iers_sequencer

`default_nettype wire

/* File: testbench/iers_mem_model.sv */
// Behavioural memory holding the stack and the vectors behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module iers_mem_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  wait_cyc,
  output logic [15:0]      rdata,
  output logic             ack
);
  logic [15:0] mem [0:255];
  logic [1:0]  cnt;
  initial begin
    ack = 1'b0;
    rdata = 16'h0000;
    cnt = 2'h0;
  end
  // One ack pulse per access after wait_cyc stall cycles; stale read data is inverted
  always @(negedge clk) begin
    if (ack || !req) begin
      ack <= 1'b0;
      cnt <= 2'h0;
      rdata <= ~rdata;
    end else if (cnt >= wait_cyc) begin
      ack <= 1'b1;
      rdata <= mem[addr[8:1]];
      if (we) mem[addr[8:1]] <= wdata;
    end else begin
      cnt <= cnt + 2'h1;
      rdata <= ~rdata;
    end
  end
endmodule : iers_mem_model
`default_nettype wire

/* File: testbench/interrupt_entry_return_sequencer_bench.sv */
// Self-checking bench for the entry/return sequencer
`timescale 1ns/1ps
`default_nettype none
module interrupt_entry_return_sequencer_bench
  import iers_pkg::*;
;
  logic REF_CLK = 1'b0, RST_N = 1'b0, IRQ_REQ = 1'b0, INSN_BOUNDARY = 1'b0;
  logic [7:0]  IRQ_VECTOR = 8'h00;
  logic [1:0]  CMD = 2'h0, wt = 2'h0;
  logic [15:0] LINK_IN = 16'h0, IP_IN = 16'h0, SP_IN = 16'h0, PSW_IN = 16'h0;
  logic [15:0] rdata, addr, wdata, ip_o, sp_o, ps_o, lk_o, c_ip, c_sp, c_ps, c_lk;
  logic        ack, req, we, lwe, tkn, busy, done, s_tk, s_lw;
  int          error_cnt = 0, compares = 0;
  always #25 REF_CLK = ~REF_CLK;
  iers_sequencer u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .IRQ_REQ(IRQ_REQ),
    .IRQ_VECTOR(IRQ_VECTOR), .INSN_BOUNDARY(INSN_BOUNDARY), .CMD(CMD), .LINK_IN(LINK_IN),
    .IP_IN(IP_IN), .SP_IN(SP_IN), .PSW_IN(PSW_IN), .MEM_RDATA(rdata), .MEM_ACK(ack),
    .MEM_REQ(req), .MEM_WE(we), .MEM_ADDR(addr), .MEM_WDATA(wdata),
    .INSTRUCTION_POINTER(ip_o), .STACK_POINTER(sp_o), .PROCESSOR_STATUS_WORD(ps_o),
    .LINK_OUT(lk_o), .LINK_WE(lwe), .IRQ_TAKEN(tkn), .BUSY(busy), .DONE(done));
  iers_mem_model u_mem (.clk(REF_CLK), .req(req), .we(we), .addr(addr), .wdata(wdata),
    .wait_cyc(wt), .rdata(rdata), .ack(ack));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk
  // Launch one sequence and capture the outputs in the DONE cycle
  task automatic run(input logic [1:0] c, input logic irq, input logic [15:0] sp, ip, ps);
    int n;
    n = 0;
    @(negedge REF_CLK);
    {CMD, IRQ_REQ, INSN_BOUNDARY, SP_IN, IP_IN, PSW_IN} = {c, irq, 1'b1, sp, ip, ps};
    s_tk = 1'b0;
    s_lw = 1'b0;
    @(posedge REF_CLK) #1;
    while (done !== 1'b1 && n < 100) begin
      if (tkn === 1'b1) s_tk = 1'b1;
      if (lwe === 1'b1) s_lw = 1'b1;
      @(negedge REF_CLK) {CMD, IRQ_REQ} = 3'h0;
      @(posedge REF_CLK) #1;
      n++;
    end
    if (lwe === 1'b1) s_lw = 1'b1;
    {c_ip, c_sp, c_ps, c_lk} = {ip_o, sp_o, ps_o, lk_o};
    chk("sequence end", 16'h0, (n == 100) ? 16'h1 : 16'h0);
  endtask : run
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_entry(input logic [15:0] sp, ip, ps, nip, nps, input logic [7:0] v);
    @(negedge REF_CLK) IRQ_VECTOR = v;
    run(CMD_NONE, 1'b1, sp, ip, ps);
    chk("irq taken", 16'h1, {15'h0, s_tk});
    chk("saved status", ps, u_mem.mem[(sp - 16'h2) >> 1]);
    chk("saved pointer", ip, u_mem.mem[(sp - 16'h4) >> 1]);
    chk("stack after entry", sp - 16'h4, c_sp);
    chk("vector pointer", nip, c_ip);
    chk("vector status", nps, c_ps);
  endtask : t_entry
  task automatic t_rfi(input logic [15:0] sp, eip, eps);
    run(CMD_RFI, 1'b0, sp, 16'h0ff0, 16'h0ff0);
    chk("return pointer", eip, c_ip);
    chk("return status", eps, c_ps);
    chk("stack after return", sp + 16'h4, c_sp);
  endtask : t_rfi
  task automatic t_refuse();
    @(negedge REF_CLK) {IRQ_REQ, INSN_BOUNDARY} = 2'b10;
    repeat (5) @(posedge REF_CLK) #1 chk("busy off boundary", 16'h0, {15'h0, busy});
    @(negedge REF_CLK) IRQ_REQ = 1'b0;
  endtask : t_refuse
  task automatic t_xchg_sret();
    u_mem.mem[8'h40] = 16'h0300;
    run(CMD_XCHG, 1'b0, 16'h0080, 16'h0200, 16'h0001);
    chk("exchange target", 16'h0300, c_ip);
    chk("exchange old pointer", 16'h0200, u_mem.mem[8'h40]);
    chk("exchange stack", 16'h0080, c_sp);
    @(negedge REF_CLK) LINK_IN = 16'h0444;
    run(CMD_SRET, 1'b0, 16'h0080, 16'h0300, 16'h0001);
    chk("link to pointer", 16'h0444, c_ip);
    chk("popped link", 16'h0200, c_lk);
    chk("link strobe", 16'h1, {15'h0, s_lw});
    chk("stack after link pop", 16'h0082, c_sp);
  endtask : t_xchg_sret
  task automatic final_report();
    $display("comparisons %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    // Vectors sit at low addresses chosen by the requesting device
    {u_mem.mem[8'h08], u_mem.mem[8'h09]} = {16'h0080, 16'h2345};
    {u_mem.mem[8'h0a], u_mem.mem[8'h0b]} = {16'h00a0, 16'h3456};
    repeat (4) @(posedge REF_CLK);
    #1 chk("busy in reset", 16'h0, {15'h0, busy});
    @(negedge REF_CLK) RST_N = 1'b1;
    t_refuse();
    t_entry(16'h0100, 16'h0040, 16'h00e0, 16'h0080, 16'h2345, 8'h10);
    wt = 2'h3;
    t_entry(16'h00fc, 16'h0090, 16'h2345, 16'h00a0, 16'h3456, 8'h14);
    t_rfi(16'h00f8, 16'h0090, 16'h2345);
    wt = 2'h0;
    t_rfi(16'h00fc, 16'h0040, 16'h00e0);
    t_xchg_sret();
    final_report();
  end
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule : interrupt_entry_return_sequencer_bench
`default_nettype wire
